// ---- rtl/uart_baud_tick.sv ----
`default_nettype none
module uart_baud_tick (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       doubler_i,
  input  wire logic       t1_ovf_i,
  output logic            os_tick_o,
  output logic            m0_tick_o,
  output logic            m0_half_o
);
  logic [3:0] cnt_ff;
  logic [3:0] limit;
  logic       step;
  logic       wrap;

  always_comb begin
    limit = uart_pkg::MODE0_LAST;
    step  = 1'b1;
    unique case (mode_i)
      uart_pkg::MODE0: begin
        limit = uart_pkg::MODE0_LAST;
      end
      uart_pkg::MODE2: begin
        limit = (doubler_i ? (uart_pkg::MODE2_TICK >> 1) : uart_pkg::MODE2_TICK) - 4'd1;
      end
      default: begin
        // Timer overflows clock modes 1 and 3, whatever the timer's own mode
        step  = t1_ovf_i;
        limit = (doubler_i ? (uart_pkg::T1_TICK >> 1) : uart_pkg::T1_TICK) - 4'd1;
      end
    endcase
  end

  assign wrap      = step && (cnt_ff >= limit);
  assign os_tick_o = wrap && (mode_i != uart_pkg::MODE0);
  assign m0_tick_o = wrap && (mode_i == uart_pkg::MODE0);
  assign m0_half_o = step && (mode_i == uart_pkg::MODE0) && (cnt_ff == uart_pkg::MODE0_HALF);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
    end else if (wrap) begin
      cnt_ff <= 4'h0;
    end else if (step) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule : uart_baud_tick
`default_nettype wire

// ---- rtl/uart_control_and_baud.sv ----
`default_nettype none
// Behaviour
// - Bits 7:6 select mode zero to three
// - Multiprocessor enable ignored in mode zero
// - Mode one: enable gates flag on stop
// - Modes two, three: enable gates on ninth
// - Receive only while receive-allow bit set
// - Ninth transmitted bit from control field
// - Received ninth bit or stop captured
// - Transmit flag: mode0 bit eight, else stop
// - Receive flag: mode0 bit eight, else mid-stop
// - Flags cleared only by software writes
// - Mode zero rate is clock over twelve
// - Mode two rate clock over 64 or 32
// - Modes one, three: overflows times doubler over 32
// - Any timer overflow source is accepted
// - Auto-reload rate follows from overflow rate
// - Two control registers, 98h and D8h, reset 00h
// - Data write starts transmit; start bit receives, mode0: allow bit set, flag clear
// - Data write to transmitter, read from receiver
module uart_control_and_baud #(
  parameter int NUM_PORTS = uart_pkg::NUM_PORTS
) (
  input  wire logic                 clock_i,
  input  wire logic                 arst_n_i,
  input  wire logic [7:0]           sfr_addr_i,
  input  wire logic                 sfr_wr_i,
  input  wire logic [7:0]           sfr_wdata_i,
  input  wire logic                 sfr_rd_i,
  output logic      [7:0]           sfr_rdata_o,
  input  wire logic                 baud_doubler_i,
  input  wire logic [NUM_PORTS-1:0] t1_overflow_i,
  input  wire logic [NUM_PORTS-1:0] rxd_i,
  output logic      [NUM_PORTS-1:0] rxd_o,
  output logic      [NUM_PORTS-1:0] rxd_oe_o,
  output logic      [NUM_PORTS-1:0] txd_o,
  output logic      [NUM_PORTS-1:0] irq_o
);
  logic                 rst_meta_ff;
  logic                 rst_n_ff;
  logic                 doubler_ff;
  logic [NUM_PORTS-1:0] ovf_ff;
  logic [7:0]           rdata_ff;
  logic [NUM_PORTS-1:0] irq_ff;
  logic [7:0]           ctrl_ff   [NUM_PORTS];
  logic [7:0]           rx_buf_ff [NUM_PORTS];

  // Reset release through two flops
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      doubler_ff <= 1'b0;
      ovf_ff     <= '0;
    end else begin
      doubler_ff <= baud_doubler_i;
      ovf_ff     <= t1_overflow_i;
    end
  end

  function automatic logic is_ctrl_addr(input logic [7:0] addr, input int port);
    is_ctrl_addr = (port == 0) ? (addr == uart_pkg::UART0_CONTROL_ADDR)
                               : (addr == uart_pkg::UART1_CONTROL_ADDR);
  endfunction : is_ctrl_addr

  function automatic logic is_data_addr(input logic [7:0] addr, input int port);
    is_data_addr = (port == 0) ? (addr == uart_pkg::UART0_DATA_ADDR)
                               : (addr == uart_pkg::UART1_DATA_ADDR);
  endfunction : is_data_addr

  // Registered read port
  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rdata_ff <= uart_pkg::READ_UNMAPPED;
    end else if (sfr_rd_i) begin
      rdata_ff <= uart_pkg::READ_UNMAPPED;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (is_ctrl_addr(sfr_addr_i, p)) begin
          rdata_ff <= ctrl_ff[p];
        end
        if (is_data_addr(sfr_addr_i, p)) begin
          rdata_ff <= rx_buf_ff[p];
        end
      end
    end
  end
  assign sfr_rdata_o = rdata_ff;

  always_ff @(posedge clock_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      irq_ff <= '0;
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        irq_ff[p] <= ctrl_ff[p][uart_pkg::TX_DONE_BIT] | ctrl_ff[p][uart_pkg::RX_DONE_BIT];
      end
    end
  end
  assign irq_o = irq_ff;

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
    uart_pkg::tx_state_t tx_state_ff;
    uart_pkg::rx_state_t rx_state_ff;
    logic [10:0] tx_shift_ff;
    logic [3:0]  tx_left_ff;
    logic [3:0]  tx_os_ff;
    logic [8:0]  rx_shift_ff;
    logic [3:0]  rx_left_ff;
    logic [3:0]  rx_os_ff;
    logic        rxd_prev_ff;
    logic        txd_ff;
    logic        rxd_out_ff;
    logic        rxd_oe_ff;
    logic        ti_set_ff;
    logic        ri_set_ff;
    logic        rb8_val_ff;
    logic [1:0]  mode;
    logic        nine;
    logic        mp_en;
    logic        rx_en;
    logic        ctrl_wr;
    logic        data_wr;
    logic        os_tick;
    logic        m0_tick;
    logic        m0_half;
    logic        stop_ok;
    logic [7:0]  nxt_ctrl;
    logic        m0_last;

    assign mode    = uart_pkg::mode_of(ctrl_ff[g]);
    assign nine    = uart_pkg::nine_bit(mode);
    assign mp_en   = ctrl_ff[g][uart_pkg::MULTIPROC_ENABLE_BIT];
    assign rx_en   = ctrl_ff[g][uart_pkg::RX_ENABLE_BIT];
    assign ctrl_wr = sfr_wr_i && is_ctrl_addr(sfr_addr_i, g);
    assign data_wr = sfr_wr_i && is_data_addr(sfr_addr_i, g);
    // Closing bit time of a mode 0 transfer: no further shift clock pulse
    assign m0_last = (tx_state_ff == uart_pkg::TX_SEND) ? (tx_left_ff == 4'h0)
                                                        : (rx_left_ff == 4'h0);

    uart_baud_tick uart_baud_tick_inst (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_ff),
      .mode_i    (mode),
      .doubler_i (doubler_ff),
      .t1_ovf_i  (ovf_ff[g]),
      .os_tick_o (os_tick),
      .m0_tick_o (m0_tick),
      .m0_half_o (m0_half)
    );

    // Hardware set of a flag wins over a software clear in the same cycle
    always_comb begin
      nxt_ctrl = ctrl_ff[g];
      if (ctrl_wr) begin
        nxt_ctrl = sfr_wdata_i;
      end
      if (ti_set_ff) begin
        nxt_ctrl[uart_pkg::TX_DONE_BIT] = 1'b1;
      end
      if (ri_set_ff) begin
        nxt_ctrl[uart_pkg::RX_DONE_BIT]  = 1'b1;
        nxt_ctrl[uart_pkg::RX_NINTH_BIT] = rb8_val_ff;
      end
    end

    always_ff @(posedge clock_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        ctrl_ff[g] <= uart_pkg::CONTROL_RESET;
      end else begin
        ctrl_ff[g] <= nxt_ctrl;
      end
    end

    // Transmitter
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        tx_state_ff <= uart_pkg::TX_IDLE;
        tx_shift_ff <= '1;
        tx_left_ff  <= 4'h0;
        tx_os_ff    <= 4'h0;
        ti_set_ff   <= 1'b0;
      end else begin
        ti_set_ff <= 1'b0;
        if (data_wr) begin
          tx_state_ff <= uart_pkg::TX_SEND;
          tx_os_ff    <= 4'h0;
          if (mode == uart_pkg::MODE0) begin
            tx_shift_ff <= {3'b111, sfr_wdata_i};
            tx_left_ff  <= uart_pkg::BITS_8;
          end else begin
            tx_shift_ff <= {1'b1, nine ? ctrl_ff[g][uart_pkg::TX_NINTH_BIT] : 1'b1,
                            sfr_wdata_i, 1'b0};
            tx_left_ff  <= nine ? uart_pkg::FRAME_BITS_11 : uart_pkg::FRAME_BITS_10;
          end
        end else if (tx_state_ff == uart_pkg::TX_SEND) begin
          if (mode == uart_pkg::MODE0) begin
            if (m0_tick) begin
              if (tx_left_ff == 4'h0) begin
                tx_state_ff <= uart_pkg::TX_IDLE;
                ti_set_ff   <= 1'b1;
              end else begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_left_ff  <= tx_left_ff - 4'h1;
              end
            end
          end else if (os_tick) begin
            tx_os_ff <= tx_os_ff + 4'h1;
            if (tx_os_ff == 4'h0) begin
              if (tx_left_ff == 4'h0) begin
                tx_state_ff <= uart_pkg::TX_IDLE;
              end else begin
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
                tx_left_ff  <= tx_left_ff - 4'h1;
                if (tx_left_ff == 4'h1) begin
                  ti_set_ff <= 1'b1;
                end
              end
            end
          end
        end
      end
    end

    // Receiver
    assign stop_ok = !mp_en || (nine ? rx_shift_ff[8] : rxd_i[g]);

    always_ff @(posedge clock_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        rx_state_ff <= uart_pkg::RX_IDLE;
        rx_shift_ff <= 9'h000;
        rx_left_ff  <= 4'h0;
        rx_os_ff    <= 4'h0;
        rxd_prev_ff <= 1'b1;
        ri_set_ff   <= 1'b0;
        rb8_val_ff  <= 1'b0;
        rx_buf_ff[g] <= 8'h00;
      end else begin
        ri_set_ff   <= 1'b0;
        rxd_prev_ff <= rxd_i[g];
        if (os_tick) begin
          rx_os_ff <= rx_os_ff + 4'h1;
        end
        if (!rx_en) begin
          rx_state_ff <= uart_pkg::RX_IDLE;
        end else begin
          unique case (rx_state_ff)
            uart_pkg::RX_IDLE: begin
              if (mode == uart_pkg::MODE0) begin
                if (!ctrl_ff[g][uart_pkg::RX_DONE_BIT] && tx_state_ff == uart_pkg::TX_IDLE
                    && !data_wr && !ri_set_ff) begin
                  rx_state_ff <= uart_pkg::RX_SHIFT0;
                  rx_left_ff  <= uart_pkg::BITS_8;
                end
              end else if (rxd_prev_ff && !rxd_i[g]) begin
                rx_state_ff <= uart_pkg::RX_START;
                rx_os_ff    <= 4'h0;
              end
            end
            uart_pkg::RX_START: begin
              if (os_tick && rx_os_ff == uart_pkg::OS_MID) begin
                rx_os_ff    <= 4'h0;
                rx_left_ff  <= nine ? 4'd9 : uart_pkg::BITS_8;
                rx_state_ff <= rxd_i[g] ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
              end
            end
            uart_pkg::RX_BITS: begin
              if (os_tick && rx_os_ff == uart_pkg::OS_LAST) begin
                rx_shift_ff <= {rxd_i[g], rx_shift_ff[8:1]};
                rx_left_ff  <= rx_left_ff - 4'h1;
                if (rx_left_ff == 4'h1) begin
                  rx_state_ff <= uart_pkg::RX_STOP;
                end
              end
            end
            uart_pkg::RX_STOP: begin
              if (os_tick && rx_os_ff == uart_pkg::OS_LAST) begin
                rx_state_ff <= uart_pkg::RX_IDLE;
                if (stop_ok) begin
                  ri_set_ff    <= 1'b1;
                  rb8_val_ff   <= nine ? rx_shift_ff[8] : rxd_i[g];
                  rx_buf_ff[g] <= nine ? rx_shift_ff[7:0] : rx_shift_ff[8:1];
                end
              end
            end
            uart_pkg::RX_SHIFT0: begin
              // Multiprocessor enable plays no part here
              // Sample only on a rising shift clock that followed a low phase
              if (m0_half && !txd_ff) begin
                rx_shift_ff <= {rxd_i[g], rx_shift_ff[8:1]};
                rx_left_ff  <= rx_left_ff - 4'h1;
              end
              if (m0_tick && rx_left_ff == 4'h0) begin
                rx_state_ff  <= uart_pkg::RX_IDLE;
                ri_set_ff    <= 1'b1;
                rb8_val_ff   <= ctrl_ff[g][uart_pkg::RX_NINTH_BIT];
                rx_buf_ff[g] <= rx_shift_ff[8:1];
              end
            end
          endcase
        end
      end
    end

    // Pins: in mode 0 the data pin is two-way and the transmit pin is the shift clock
    always_ff @(posedge clock_i or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
        txd_ff     <= 1'b1;
        rxd_out_ff <= 1'b1;
        rxd_oe_ff  <= 1'b0;
      end else if (mode == uart_pkg::MODE0) begin
        rxd_oe_ff <= (tx_state_ff == uart_pkg::TX_SEND);
        if (tx_state_ff == uart_pkg::TX_SEND || rx_state_ff == uart_pkg::RX_SHIFT0) begin
          if (m0_tick) begin
            txd_ff     <= m0_last;
            rxd_out_ff <= tx_shift_ff[0];
          end else if (m0_half) begin
            txd_ff <= 1'b1;
          end
        end else begin
          txd_ff <= 1'b1;
        end
      end else begin
        rxd_oe_ff  <= 1'b0;
        rxd_out_ff <= 1'b1;
        if (tx_state_ff == uart_pkg::TX_SEND && os_tick && tx_os_ff == 4'h0) begin
          txd_ff <= (tx_left_ff == 4'h0) ? 1'b1 : tx_shift_ff[0];
        end else if (tx_state_ff == uart_pkg::TX_IDLE) begin
          txd_ff <= 1'b1;
        end
      end
    end

    assign txd_o[g]    = txd_ff;
    assign rxd_o[g]    = rxd_out_ff;
    assign rxd_oe_o[g] = rxd_oe_ff;
  end
endmodule : uart_control_and_baud
`default_nettype wire

// ---- rtl/uart_pkg.sv ----
`default_nettype none
package uart_pkg;
  localparam int NUM_PORTS = 2;

  // Special-function register addresses
  localparam logic [7:0] UART0_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] UART0_DATA_ADDR    = 8'h99;
  localparam logic [7:0] UART1_CONTROL_ADDR = 8'hd8;
  localparam logic [7:0] UART1_DATA_ADDR    = 8'hd9;
  localparam logic [7:0] CONTROL_RESET      = 8'h00;
  localparam logic [7:0] READ_UNMAPPED      = 8'h00;

  // Control register field positions
  localparam int MODE_SELECT_HI_BIT   = 7;
  localparam int MODE_SELECT_LO_BIT   = 6;
  localparam int MULTIPROC_ENABLE_BIT = 5;
  localparam int RX_ENABLE_BIT        = 4;
  localparam int TX_NINTH_BIT         = 3;
  localparam int RX_NINTH_BIT         = 2;
  localparam int TX_DONE_BIT          = 1;
  localparam int RX_DONE_BIT          = 0;

  // Mode codes as {mode_select_hi, mode_select_lo}
  localparam logic [1:0] MODE0 = 2'b00;
  localparam logic [1:0] MODE1 = 2'b01;
  localparam logic [1:0] MODE2 = 2'b10;
  localparam logic [1:0] MODE3 = 2'b11;

  // Bit-rate divisors
  localparam int OSC_DIV_MODE0    = 12;
  localparam int OSC_DIV_MODE2    = 64;
  localparam int T1_OVF_DIV       = 32;
  localparam int OVERSAMPLE       = 16;
  localparam logic [3:0] MODE0_LAST    = 4'(OSC_DIV_MODE0 - 1);
  localparam logic [3:0] MODE0_HALF    = 4'(OSC_DIV_MODE0 / 2 - 1);
  localparam logic [3:0] MODE2_TICK    = 4'(OSC_DIV_MODE2 / OVERSAMPLE);
  localparam logic [3:0] T1_TICK       = 4'(T1_OVF_DIV / OVERSAMPLE);
  localparam logic [3:0] OS_MID        = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] OS_LAST       = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] BITS_8        = 4'd8;
  localparam logic [3:0] FRAME_BITS_10 = 4'd10;
  localparam logic [3:0] FRAME_BITS_11 = 4'd11;

  typedef enum {TX_IDLE, TX_SEND} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_SHIFT0} rx_state_t;

  function automatic logic [1:0] mode_of(input logic [7:0] ctrl);
    mode_of = {ctrl[MODE_SELECT_HI_BIT], ctrl[MODE_SELECT_LO_BIT]};
  endfunction : mode_of

  function automatic logic nine_bit(input logic [1:0] mode);
    nine_bit = mode[1];
  endfunction : nine_bit
endpackage : uart_pkg
`default_nettype wire

// ---- test/uart_control_and_baud_asserts.sv ----
`default_nettype none
module uart_control_and_baud_asserts #(
  parameter int NUM_PORTS = 2
) (
  input wire logic                 clock_i,
  input wire logic                 arst_n_i,
  input wire logic [7:0]           sfr_addr_i,
  input wire logic                 sfr_wr_i,
  input wire logic [7:0]           sfr_wdata_i,
  input wire logic                 sfr_rd_i,
  input wire logic [7:0]           sfr_rdata_o,
  input wire logic                 baud_doubler_i,
  input wire logic [NUM_PORTS-1:0] t1_overflow_i,
  input wire logic [NUM_PORTS-1:0] rxd_i,
  input wire logic [NUM_PORTS-1:0] rxd_o,
  input wire logic [NUM_PORTS-1:0] rxd_oe_o,
  input wire logic [NUM_PORTS-1:0] txd_o,
  input wire logic [NUM_PORTS-1:0] irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd1_ff;
  logic [7:0] wd2_ff;

  always_ff @(posedge clock_i) begin
    wd1_ff <= sfr_wdata_i;
    wd2_ff <= wd1_ff;
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  property p_unmapped_zero;
    sfr_rd_i && !(sfr_addr_i inside {8'h98, 8'h99, 8'hd8, 8'hd9}) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  property p_rdata_hold;
    !sfr_rd_i |=> $stable(sfr_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_irq0_clear;
    $fell(irq_o[0]) |-> $past(sfr_wr_i && sfr_addr_i == 8'h98, 2);
  endproperty
  a_irq0_clear: assert property (p_irq0_clear) else $error("port 0 flag cleared alone");
  property p_irq1_clear;
    $fell(irq_o[1]) |-> $past(sfr_wr_i && sfr_addr_i == 8'hd8, 2);
  endproperty
  a_irq1_clear: assert property (p_irq1_clear) else $error("port 1 flag cleared alone");
  property p_ctrl0_back;
    sfr_wr_i && sfr_addr_i == 8'h98 ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h98
      |=> sfr_rdata_o[7:3] == wd2_ff[7:3];
  endproperty
  a_ctrl0_back: assert property (p_ctrl0_back) else $error("control 0 readback wrong");
  property p_ctrl1_back;
    sfr_wr_i && sfr_addr_i == 8'hd8 ##1 sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'hd8
      |=> sfr_rdata_o[7:3] == wd2_ff[7:3];
  endproperty
  a_ctrl1_back: assert property (p_ctrl1_back) else $error("control 1 readback wrong");
  property p_m0_low;
    $fell(txd_o[0]) && rxd_oe_o[0] |=> (!txd_o[0])[*4] ##[1:3] txd_o[0];
  endproperty
  a_m0_low: assert property (p_m0_low) else $error("shift clock low phase wrong");
  property p_m0_period;
    $fell(txd_o[0]) && rxd_oe_o[0] |=> (!$fell(txd_o[0]))[*8] ##1 (!$fell(txd_o[0]))[*3];
  endproperty
  a_m0_period: assert property (p_m0_period) else $error("shift clock too fast");
  property p_data_idle;
    !rxd_oe_o[0] && $past(!rxd_oe_o[0]) |-> rxd_o[0];
  endproperty
  a_data_idle: assert property (p_data_idle) else $error("data pin not idle high");
  property p_data_idle1;
    !rxd_oe_o[1] && $past(!rxd_oe_o[1]) |-> rxd_o[1];
  endproperty
  a_data_idle1: assert property (p_data_idle1) else $error("port 1 data pin not idle");

  c_shift_tx: cover property ($rose(rxd_oe_o[0]));
  c_irq: cover property ($rose(irq_o[0]));
  c_shift_rx: cover property ($fell(txd_o[0]) && !rxd_oe_o[0]);
  c_unmapped: cover property (sfr_rd_i && sfr_addr_i == 8'h55);
endmodule : uart_control_and_baud_asserts

bind uart_control_and_baud uart_control_and_baud_asserts #(.NUM_PORTS(NUM_PORTS)) asserts_inst (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
  .baud_doubler_i(baud_doubler_i), .t1_overflow_i(t1_overflow_i), .rxd_i(rxd_i),
  .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .irq_o(irq_o));
`default_nettype wire

// ---- test/uart_control_and_baud_bench.sv ----
`default_nettype none
module uart_control_and_baud_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
  logic       dbl = 1'b1, ovf = 1'b0, line, got, b9, sm, rn, bt, acc;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, c, d;
  logic [1:0] rxo, oe, txd, irq, m2;
  logic [9:0] frame, rq[$], fq[$];
  logic [4:0] rx_case[7] = '{5'b01011, 5'b01010, 5'b01110, 5'b10110, 5'b10111, 5'b11010, 5'b11001};
  int         fail_count = 0, checks = 0, seen = 0;

  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) ovf <= #1 ~ovf;
  always @(posedge clock_i) rd_q <= rd;

  uart_control_and_baud uart_control_and_baud_inst (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
    .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .baud_doubler_i(dbl),
    .t1_overflow_i({ovf, ovf}), .rxd_i({txd[1], line}), .rxd_o(rxo), .rxd_oe_o(oe),
    .txd_o(txd), .irq_o(irq));
  uart_line_peer uart_line_peer_inst (
    .clock_i(clock_i), .txd_i(txd[0]), .oe_i(oe[0]), .data_i(rxo[0]), .line_o(line),
    .got_o(got), .frame_o(frame));

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic note(input logic [9:0] g, input logic [9:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : note
  task automatic cmp_read(input logic [8:0] g, input logic [8:0] e);
    note({1'b0, g}, {1'b0, e});
  endtask : cmp_read
  task automatic cmp_frame(input logic [9:0] g, input logic [9:0] e);
    note(g, e);
  endtask : cmp_frame

  // Read results carry {port, irq, byte}; frames carry {stop, ninth, data}
  always @(posedge clock_i) begin
    logic [9:0] e;
    if (rd_q) begin
      e = rq.pop_front();
      cmp_read({irq[e[9]], rdata}, e[8:0]);
    end
    if (got) begin
      seen++;
      cmp_frame(frame, fq.pop_front());
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    {wr, rd} = 2'b10;
    addr = a;
    wdata = v;
    @(posedge clock_i);
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] v, input logic i);
    rq.push_back({a[6], i, v});
    {wr, rd} = 2'b01;
    addr = a;
    @(posedge clock_i);
    #1;
  endtask : rd_reg
  task automatic idle(input int n);
    {wr, rd} = 2'b00;
    repeat (n) @(posedge clock_i);
    #1;
  endtask : idle
  task automatic wait_frame;
    int n;
    n = seen;
    for (int k = 0; k < 4000 && seen == n; k++) @(posedge clock_i);
    #1;
    if (seen == n) begin
      fail_count++;
      give_verdict();
    end
  endtask : wait_frame

  initial begin
    void'($urandom(96));
    repeat (2) @(posedge clock_i);
    #1 arst_n_i = 1'b1;
    idle(3);
    rd_reg(8'h98, 8'h00, 1'b0);
    rd_reg(8'hd8, 8'h00, 1'b0);
    rd_reg(8'h55, 8'h00, 1'b0);
    wr_reg(8'hd8, 8'h02);
    rd_reg(8'hd8, 8'h02, 1'b1);
    wr_reg(8'hd8, 8'h00);
    rd_reg(8'hd8, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      c = 8'($urandom) & 8'hec;
      wr_reg({1'b1, i[0], 6'h18}, c);
      rd_reg({1'b1, i[0], 6'h18}, c, 1'b0);
    end
    wr_reg(8'hd8, 8'h00);
    wr_reg(8'h98, 8'h00);
    idle(1);
    for (int m = 0; m < 4; m++) begin
      b9 = 1'($urandom);
      d = 8'($urandom);
      c = {m[1:0], 2'b00, b9, 3'b000};
      dbl = (m == 1);
      uart_line_peer_inst.bits = (m == 1) ? 32 : 64;
      uart_line_peer_inst.mode = m;
      fq.push_back((m == 0) ? {2'b10, d} : {1'b1, b9 & m[1], d});
      wr_reg(8'h98, c);
      wr_reg(8'h99, d);
      idle(1);
      wait_frame();
      idle(20);
      rd_reg(8'h98, c | 8'h02, 1'b1);
      wr_reg(8'h98, c);
      rd_reg(8'h98, c, 1'b0);
      idle(1);
    end
    dbl = 1'b1;
    uart_line_peer_inst.bits = 32;
    foreach (rx_case[i]) begin
      {m2, sm, rn, bt} = rx_case[i];
      acc = rn & (~sm | bt);
      d = 8'($urandom);
      c = {m2, sm, rn, 4'h0};
      uart_line_peer_inst.mode = int'(m2);
      wr_reg(8'h98, c);
      idle(2);
      uart_line_peer_inst.send_frame(d, bt & m2[1], bt | m2[1]);
      idle(20);
      rd_reg(8'h98, c | {5'h00, acc & bt, 1'b0, acc}, acc);
      if (acc) rd_reg(8'h99, d, 1'b1);
      wr_reg(8'h98, 8'h00);
      idle(1);
    end
    // Mode 0 reception on port 0, multiprocessor enable kept at 0
    uart_line_peer_inst.mode = 0;
    d = 8'($urandom);
    fork
      uart_line_peer_inst.shift_out(d);
    join_none
    wr_reg(8'h98, 8'h10);
    idle(150);
    rd_reg(8'h98, 8'h11, 1'b1);
    rd_reg(8'h99, d, 1'b1);
    wr_reg(8'h98, 8'h00);
    idle(1);
    // Port 1 in mode 1, its transmit pin looped back to its receive pin
    d = 8'($urandom);
    wr_reg(8'hd8, 8'h50);
    wr_reg(8'hd9, d);
    idle(400);
    rd_reg(8'hd8, 8'h57, 1'b1);
    rd_reg(8'hd9, d, 1'b1);
    idle(2);
    give_verdict();
  end
endmodule : uart_control_and_baud_bench
`default_nettype wire

// ---- test/uart_line_peer.sv ----
`default_nettype none
module uart_line_peer (
  input  wire logic       clock_i,
  input  wire logic       txd_i,
  input  wire logic       oe_i,
  input  wire logic       data_i,
  output logic            line_o,
  output logic            got_o,
  output logic      [9:0] frame_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int bits = 32;
  int mode = 0;

  initial begin
    line_o = 1'b1;
    got_o = 1'b0;
    frame_o = 10'h000;
  end

  task automatic hold;
    repeat (bits) @(posedge clock_i);
    #1;
  endtask : hold

  task automatic post(input logic [9:0] f);
    frame_o = f;
    got_o = 1'b1;
    @(posedge clock_i);
    #1 got_o = 1'b0;
  endtask : post

  // Start bit, data LSB first, ninth bit in modes 2 and 3, then stop level
  task automatic send_frame(input logic [7:0] d, input logic b9, input logic stop);
    line_o = 1'b0;
    hold();
    for (int i = 0; i < 8; i++) begin
      line_o = d[i];
      hold();
    end
    if (mode > 1) begin
      line_o = b9;
      hold();
    end
    line_o = stop;
    hold();
    line_o = 1'b1;
  endtask : send_frame

  // Mode 0 receive partner: next bit presented after each falling shift clock
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd_i iff !oe_i);
      #1 line_o = d[i];
    end
    @(posedge txd_i);
    #1 line_o = 1'b1;
  endtask : shift_out

  // Frame receiver, sampling mid-bit; result is {stop, ninth, data}
  initial begin
    logic [9:0] f;
    forever begin
      @(negedge txd_i iff (mode != 0));
      f = 10'h000;
      repeat (bits / 2) @(posedge clock_i);
      for (int i = 0; i < ((mode > 1) ? 10 : 9); i++) begin
        repeat (bits) @(posedge clock_i);
        f[i] = txd_i;
      end
      if (mode < 2) f = {f[8], 1'b0, f[7:0]};
      #1 post(f);
    end
  end

  // Shift-register partner: data taken at each rising shift clock
  initial begin
    logic [7:0] m;
    forever begin
      for (int i = 0; i < 8; i++) begin
        @(posedge txd_i iff oe_i);
        m[i] = data_i;
      end
      #1 post({2'b10, m});
    end
  end
endmodule : uart_line_peer
`default_nettype wire
